//--- verilog/spr_pkg.sv
// Package for the serial port software recovery register block
package spr_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_BLOCK_HEADER   = 12'h000;
  localparam logic [11:0] OFS_LINK_TIMEOUT   = 12'h020;
  localparam logic [11:0] OFS_RESP_TIMEOUT   = 12'h024;
  localparam logic [11:0] OFS_GENERAL_CTRL   = 12'h03C;
  localparam logic [11:0] OFS_LINK_REQUEST   = 12'h040;
  localparam logic [11:0] OFS_LINK_RESPONSE  = 12'h044;
  localparam logic [11:0] OFS_LOCAL_TAG      = 12'h048;
  localparam logic [11:0] OFS_ERROR_STATUS   = 12'h058;

  // ------------------------------------------------------------
  // Field positions (bit 0 is the least significant data bit)
  // ------------------------------------------------------------
  localparam int unsigned HDR_TYPE_LSB       = 16;
  localparam logic [15:0] BLOCK_TYPE_ID      = 16'h0002;
  localparam int unsigned TIMEOUT_W          = 24;
  localparam logic [23:0] TIMEOUT_RST        = 24'hFFFFFF;
  localparam int unsigned GC_HOST            = 0;
  localparam int unsigned GC_MASTER          = 1;
  localparam int unsigned GC_DISCOVERED      = 2;
  localparam int unsigned REQ_CMD_LSB        = 29;
  localparam logic [2:0]  REQ_CMD_RST        = 3'h0;
  localparam int unsigned RSP_VALID          = 0;
  localparam int unsigned RSP_TAG_LSB        = 22;
  localparam int unsigned RSP_LINK_LSB       = 27;
  localparam int unsigned TAG_DISCARD        = 0;
  localparam int unsigned TAG_RX_LSB         = 3;
  localparam int unsigned TAG_OLDEST_LSB     = 19;
  localparam int unsigned TAG_TX_LSB         = 27;
  localparam logic [4:0]  TAG_RST            = 5'h00;
  localparam int unsigned ES_OUT_RETRY_ENC   = 11;
  localparam int unsigned ES_OUT_RETRIED     = 12;
  localparam int unsigned ES_OUT_RETRY_STOP  = 13;
  localparam int unsigned ES_OUT_ERR_ENC     = 14;
  localparam int unsigned ES_OUT_ERR_STOP    = 15;
  localparam int unsigned ES_IN_RETRY_STOP   = 21;
  localparam int unsigned ES_IN_ERR_ENC      = 22;
  localparam int unsigned ES_IN_ERR_STOP     = 23;
  localparam int unsigned ES_PW_PENDING      = 27;
  localparam int unsigned ES_PORT_ERR        = 29;
  localparam int unsigned ES_PORT_OK         = 30;
  localparam int unsigned ES_PORT_UNINIT     = 31;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       resp_rx;        // Link-response received, one cycle
    logic [4:0] resp_tag_state; // Tag status field of that response
    logic [4:0] resp_link_state;// Link status field of that response
    logic       req_sent;       // Link-request has left the port, one cycle
    logic       tx_tag_adv;     // Port sent a packet, next tag advances
    logic [4:0] rx_expected_tag;
    logic [4:0] tx_oldest_unacked_tag;
    logic       out_retry_stop;
    logic       out_err_stop;
    logic       in_retry_stop;
    logic       in_err_stop;
    logic       ack_rx;         // Packet-accepted or not-accepted seen
    logic       pw_event;       // Condition calling for a port-write
    logic       fatal_event;    // Error hardware could not recover
    logic       port_ok;
  } spr_port_stat_t;

  typedef struct packed {
    logic                 link_req;      // Send one link-request, pulse
    logic [2:0]           link_req_cmd;
    logic                 discard_tags;  // Drop unacknowledged packets, pulse
    logic                 tx_tag_load;   // Software loaded tx_next_tag, pulse
    logic [4:0]           tx_next_tag;
    logic [TIMEOUT_W-1:0] link_timeout;
    logic [TIMEOUT_W-1:0] resp_timeout;
    logic                 host;
    logic                 req_permit;
    logic                 discovered;
  } spr_port_ctrl_t;

endpackage

//--- verilog/spr_csr.sv
// Register block for software assisted serial port error recovery
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - Header: type id 0x0002 in bits 16-31, fixed next pointer in 0-15.
// - Link time-out in bits 0-23 is shared, bounds ack and link-response waits.
// - Both time-out fields reset to all ones, the longest interval.
// - Response time-out in bits 0-23 is shared, bounds request to response.
// - General control bit 0 marks host (1) or agent (0).
// - General control bit 1 clear forbids issuing requests; set allows them.
// - General control bit 2 records the device as discovered.
// - Each request write sends one link-request with command bits 29-31.
// - Response valid sets on response or send if none expected; read clears.
// - Response captures tag status in 22-26, link status in 27-31, reset zero.
// - Writing 1 to tag bit 0 discards outstanding packets; bit reads zero.
// - Tag bits 3-7 show next expected input tag, reset zero.
// - Tag bits 19-23 show oldest unacknowledged output tag.
// - Tag bits 27-31 hold next transmit tag; writing it forces retransmission.
// - Status bit 11 sets with bit 13, holds until written with 1.
// - Status bit 12 sets with bit 13, clears on accept or not-accept.
// - Bits 13, 15, 21, 23 show retry and error stopped states.
// - Status bit 14 sets with bit 15, holds until written with 1.
// - Status bit 22 sets with bit 23, holds until written with 1.
// - Status bit 27 sets on port-write condition, holds until written with 1.
// - Status bit 29 sets on unrecoverable error, holds until written with 1.
// - Bit 30 port ok, bit 31 uninitialised resets 1, never both set.
module spr_csr #(
  parameter int unsigned ADDR_W      = 12,
  parameter logic [15:0] NEXT_PTR    = 16'h0000,
  parameter logic        HOST_RST    = 1'b0,
  parameter logic        MASTER_RST  = 1'b0,
  parameter logic        DISC_RST    = 1'b0,
  parameter logic [7:0]  NORESP_MASK = 8'h08
) (
  // Clock, reset, enable
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_b,
  input  wire logic                   i_ce,
  // Register port
  input  wire logic [ADDR_W-1:0]      i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [31:0]            o_rdata,
  // Port logic
  input  wire spr_pkg::spr_port_stat_t i_stat,
  output spr_pkg::spr_port_ctrl_t     o_ctrl
);

  // Offsets up to 0x58 need seven address bits
  if (ADDR_W < 7 || ADDR_W > 12)
  begin : g_bad_addr_w
    $error("spr_csr: ADDR_W must lie in 7..12");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0]            rdata;
    spr_pkg::spr_port_ctrl_t ctrl;
    logic                   resp_valid;
    logic [4:0]             resp_tag;
    logic [4:0]             resp_link;
    logic                   noresp_wait;
    logic                   out_retry_enc;
    logic                   out_retried;
    logic                   retry_stop_q;
    logic                   out_err_enc;
    logic                   in_err_enc;
    logic                   pw_pend;
    logic                   port_err;
  } spr_state_t;

  spr_state_t st;
  spr_state_t next_st;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    hit = (12'(a) == ofs);
  endfunction

  // Sticky flag: hardware set wins over a write-one clear
  function automatic logic sticky(input logic cur, input logic set,
                                  input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  logic wr_req;
  logic wr_tag;
  logic wr_es;
  logic rd_rsp;
  logic no_resp_cmd;
  logic retry_rise;

  always_comb
  begin
    wr_req      = i_wr & hit(i_addr, spr_pkg::OFS_LINK_REQUEST);
    wr_tag      = i_wr & hit(i_addr, spr_pkg::OFS_LOCAL_TAG);
    wr_es       = i_wr & hit(i_addr, spr_pkg::OFS_ERROR_STATUS);
    rd_rsp      = i_rd & hit(i_addr, spr_pkg::OFS_LINK_RESPONSE);
    no_resp_cmd = NORESP_MASK[st.ctrl.link_req_cmd];
    retry_rise  = i_stat.out_retry_stop & ~st.retry_stop_q;
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.ctrl.link_req     = 1'b0;
    next_st.ctrl.discard_tags = 1'b0;
    next_st.ctrl.tx_tag_load  = 1'b0;
    next_st.retry_stop_q      = i_stat.out_retry_stop;

    if (i_wr && hit(i_addr, spr_pkg::OFS_LINK_TIMEOUT))
      next_st.ctrl.link_timeout = i_wdata[spr_pkg::TIMEOUT_W-1:0];
    if (i_wr && hit(i_addr, spr_pkg::OFS_RESP_TIMEOUT))
      next_st.ctrl.resp_timeout = i_wdata[spr_pkg::TIMEOUT_W-1:0];
    if (i_wr && hit(i_addr, spr_pkg::OFS_GENERAL_CTRL))
    begin
      next_st.ctrl.host       = i_wdata[spr_pkg::GC_HOST];
      next_st.ctrl.req_permit = i_wdata[spr_pkg::GC_MASTER];
      next_st.ctrl.discovered = i_wdata[spr_pkg::GC_DISCOVERED];
    end

    // Link-request launch; a new request restarts the response wait
    if (wr_req)
    begin
      next_st.ctrl.link_req_cmd = i_wdata[spr_pkg::REQ_CMD_LSB +: 3];
      next_st.ctrl.link_req     = 1'b1;
      next_st.noresp_wait       = 1'b1;
    end
    else if (i_stat.req_sent)
      next_st.noresp_wait = 1'b0;

    if (i_stat.resp_rx)
    begin
      next_st.resp_tag  = i_stat.resp_tag_state;
      next_st.resp_link = i_stat.resp_link_state;
    end
    next_st.resp_valid = sticky(st.resp_valid,
                                i_stat.resp_rx |
                                (i_stat.req_sent & st.noresp_wait & no_resp_cmd),
                                rd_rsp);

    // Next transmit tag: software load beats the port's own advance
    if (wr_tag)
    begin
      next_st.ctrl.tx_next_tag  = i_wdata[spr_pkg::TAG_TX_LSB +: 5];
      next_st.ctrl.tx_tag_load  = 1'b1;
      next_st.ctrl.discard_tags = i_wdata[spr_pkg::TAG_DISCARD];
    end
    else if (i_stat.tx_tag_adv)
      next_st.ctrl.tx_next_tag = st.ctrl.tx_next_tag + 5'h01;

    next_st.out_retry_enc = sticky(st.out_retry_enc, i_stat.out_retry_stop,
                                   wr_es & i_wdata[spr_pkg::ES_OUT_RETRY_ENC]);
    next_st.out_retried   = sticky(st.out_retried, retry_rise, i_stat.ack_rx);
    next_st.out_err_enc   = sticky(st.out_err_enc, i_stat.out_err_stop,
                                   wr_es & i_wdata[spr_pkg::ES_OUT_ERR_ENC]);
    next_st.in_err_enc    = sticky(st.in_err_enc, i_stat.in_err_stop,
                                   wr_es & i_wdata[spr_pkg::ES_IN_ERR_ENC]);
    next_st.pw_pend       = sticky(st.pw_pend, i_stat.pw_event,
                                   wr_es & i_wdata[spr_pkg::ES_PW_PENDING]);
    next_st.port_err      = sticky(st.port_err, i_stat.fatal_event,
                                   wr_es & i_wdata[spr_pkg::ES_PORT_ERR]);

    // Read data; unmapped and reserved bits give zero
    next_st.rdata = 32'h00000000;
    if (i_rd)
    begin
      if (hit(i_addr, spr_pkg::OFS_BLOCK_HEADER))
        next_st.rdata = {spr_pkg::BLOCK_TYPE_ID, NEXT_PTR};
      else if (hit(i_addr, spr_pkg::OFS_LINK_TIMEOUT))
        next_st.rdata = {8'h00, st.ctrl.link_timeout};
      else if (hit(i_addr, spr_pkg::OFS_RESP_TIMEOUT))
        next_st.rdata = {8'h00, st.ctrl.resp_timeout};
      else if (hit(i_addr, spr_pkg::OFS_GENERAL_CTRL))
        next_st.rdata = {29'h00000000, st.ctrl.discovered,
                         st.ctrl.req_permit, st.ctrl.host};
      else if (hit(i_addr, spr_pkg::OFS_LINK_REQUEST))
        next_st.rdata = {st.ctrl.link_req_cmd, 29'h00000000};
      else if (hit(i_addr, spr_pkg::OFS_LINK_RESPONSE))
        next_st.rdata = {st.resp_link, st.resp_tag, 21'h000000, st.resp_valid};
      else if (hit(i_addr, spr_pkg::OFS_LOCAL_TAG))
        // Discard bit always reads zero
        next_st.rdata = {st.ctrl.tx_next_tag, 3'h0,
                         i_stat.tx_oldest_unacked_tag, 11'h000,
                         i_stat.rx_expected_tag, 3'h0};
      else if (hit(i_addr, spr_pkg::OFS_ERROR_STATUS))
        next_st.rdata = {~i_stat.port_ok, i_stat.port_ok, st.port_err, 1'b0,
                         st.pw_pend, 3'h0,
                         i_stat.in_err_stop, st.in_err_enc, i_stat.in_retry_stop,
                         5'h00,
                         i_stat.out_err_stop, st.out_err_enc,
                         i_stat.out_retry_stop, st.out_retried, st.out_retry_enc,
                         11'h000};
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      st                   <= '0;
      st.ctrl.link_timeout <= spr_pkg::TIMEOUT_RST;
      st.ctrl.resp_timeout <= spr_pkg::TIMEOUT_RST;
      st.ctrl.host         <= HOST_RST;
      st.ctrl.req_permit   <= MASTER_RST;
      st.ctrl.discovered   <= DISC_RST;
      st.ctrl.link_req_cmd <= spr_pkg::REQ_CMD_RST;
      st.ctrl.tx_next_tag  <= spr_pkg::TAG_RST;
    end
    else if (i_ce)
      st <= next_st;
  end

  assign o_rdata = st.rdata;
  assign o_ctrl  = st.ctrl;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  header_read_a: assert property (
    i_ce && i_rd && hit(i_addr, spr_pkg::OFS_BLOCK_HEADER)
    |=> o_rdata == {16'h0002, NEXT_PTR})
    else $error("header value wrong");

  req_pulse_a: assert property (
    i_ce && wr_req |=> o_ctrl.link_req &&
    o_ctrl.link_req_cmd == $past(i_wdata[31:29]))
    else $error("link-request not launched");

  req_single_a: assert property (
    o_ctrl.link_req && i_ce |=> !o_ctrl.link_req || $past(wr_req))
    else $error("link-request repeated");

  resp_clear_a: assert property (
    i_ce && rd_rsp && !i_stat.resp_rx && !i_stat.req_sent
    |=> !st.resp_valid)
    else $error("response valid not cleared by read");

  resp_capture_a: assert property (
    i_ce && i_stat.resp_rx
    |=> st.resp_tag == $past(i_stat.resp_tag_state) &&
        st.resp_link == $past(i_stat.resp_link_state) && st.resp_valid)
    else $error("response fields not captured");

  discard_pulse_a: assert property (
    i_ce && wr_tag |=> o_ctrl.discard_tags == $past(i_wdata[0]) && o_ctrl.tx_tag_load)
    else $error("discard pulse wrong");

  tag_read_a: assert property (
    i_ce && i_rd && hit(i_addr, spr_pkg::OFS_LOCAL_TAG)
    |=> o_rdata[0] == 1'b0 && o_rdata[7:3] == $past(i_stat.rx_expected_tag))
    else $error("tag status read wrong");

  retried_clear_a: assert property (
    i_ce && i_stat.ack_rx && !retry_rise |=> !st.out_retried)
    else $error("retried bit not cleared");

  retry_sticky_a: assert property (
    i_ce && retry_rise |=> st.out_retry_enc && st.out_retried)
    else $error("retry flags not set");

  ok_excl_a: assert property (
    i_ce && i_rd && hit(i_addr, spr_pkg::OFS_ERROR_STATUS)
    |=> o_rdata[30] != o_rdata[31] && o_rdata[30] == $past(i_stat.port_ok))
    else $error("port ok and uninitialised together");

  timeout_rst_a: assert property (
    $rose(i_rst_b) |-> o_ctrl.link_timeout == 24'hFFFFFF &&
    o_ctrl.resp_timeout == 24'hFFFFFF)
    else $error("time-out reset value wrong");

  link_to_wr_a: assert property (
    i_ce && i_wr && hit(i_addr, spr_pkg::OFS_LINK_TIMEOUT)
    |=> o_ctrl.link_timeout == $past(i_wdata[23:0]))
    else $error("link time-out not written");

  resp_to_wr_a: assert property (
    i_ce && i_wr && hit(i_addr, spr_pkg::OFS_RESP_TIMEOUT)
    |=> o_ctrl.resp_timeout == $past(i_wdata[23:0]))
    else $error("response time-out not written");

  host_bit_a: assert property (
    i_ce && i_wr && hit(i_addr, spr_pkg::OFS_GENERAL_CTRL)
    |=> o_ctrl.host == $past(i_wdata[0]))
    else $error("host bit not written");

  permit_bit_a: assert property (
    i_ce && i_wr && hit(i_addr, spr_pkg::OFS_GENERAL_CTRL)
    |=> o_ctrl.req_permit == $past(i_wdata[1]))
    else $error("request permission not written");

  discovered_bit_a: assert property (
    i_ce && i_wr && hit(i_addr, spr_pkg::OFS_GENERAL_CTRL)
    |=> o_ctrl.discovered == $past(i_wdata[2]))
    else $error("discovered bit not written");

  gen_read_a: assert property (
    i_ce && i_rd && hit(i_addr, spr_pkg::OFS_GENERAL_CTRL)
    |=> o_rdata == {29'h00000000, $past(o_ctrl.discovered),
                    $past(o_ctrl.req_permit), $past(o_ctrl.host)})
    else $error("general control read wrong");

  noresp_valid_a: assert property (
    i_ce && i_stat.req_sent && st.noresp_wait && no_resp_cmd |=> st.resp_valid)
    else $error("valid not set on send");

  resp_read_a: assert property (
    i_ce && rd_rsp
    |=> o_rdata[21:0] == {21'h000000, $past(st.resp_valid)})
    else $error("response read wrong");

  tag_fields_a: assert property (
    i_ce && i_rd && hit(i_addr, spr_pkg::OFS_LOCAL_TAG)
    |=> o_rdata[23:19] == $past(i_stat.tx_oldest_unacked_tag) &&
        o_rdata[31:27] == $past(o_ctrl.tx_next_tag))
    else $error("tag fields read wrong");

  tx_tag_load_a: assert property (
    i_ce && wr_tag |=> o_ctrl.tx_next_tag == $past(i_wdata[31:27]))
    else $error("next tag not loaded");

  enc_clear_a: assert property (
    i_ce && wr_es && i_wdata[11] && !i_stat.out_retry_stop
    |=> !st.out_retry_enc)
    else $error("retry-encountered not cleared");

  state_mirror_a: assert property (
    i_ce && i_rd && hit(i_addr, spr_pkg::OFS_ERROR_STATUS)
    |=> o_rdata[13] == $past(i_stat.out_retry_stop) &&
        o_rdata[15] == $past(i_stat.out_err_stop) &&
        o_rdata[21] == $past(i_stat.in_retry_stop) &&
        o_rdata[23] == $past(i_stat.in_err_stop))
    else $error("stopped states read wrong");

  out_err_sticky_a: assert property (
    i_ce && i_stat.out_err_stop |=> st.out_err_enc)
    else $error("output error flag not set");

  in_err_sticky_a: assert property (
    i_ce && i_stat.in_err_stop |=> st.in_err_enc)
    else $error("input error flag not set");

  pw_sticky_a: assert property (
    i_ce && i_stat.pw_event |=> st.pw_pend)
    else $error("port-write flag not set");

  fatal_sticky_a: assert property (
    i_ce && i_stat.fatal_event |=> st.port_err)
    else $error("port error flag not set");

  idle_rdata_a: assert property (
    i_ce && !i_rd |=> o_rdata == 32'h00000000)
    else $error("read data not zero when idle");

  status_resv_a: assert property (
    i_ce && i_rd && hit(i_addr, spr_pkg::OFS_ERROR_STATUS)
    |=> (o_rdata & 32'h171F07FF) == 32'h00000000)
    else $error("status reserved bits set");

endmodule

//--- verif/spr_port_model.sv
// Stand-in for the port logic behind the recovery registers
`timescale 1ns/1ps
module spr_port_model #(
  parameter logic [4:0] RESP_TAG  = 5'h15,
  parameter logic [4:0] RESP_LINK = 5'h0A,
  parameter logic [7:0] NORESP    = 8'h08
) (
  // Clock and reset
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst_b,
  // Block side
  input  wire spr_pkg::spr_port_ctrl_t i_ctrl,
  input  wire spr_pkg::spr_port_stat_t i_knob,
  output spr_pkg::spr_port_stat_t      o_stat
);
  logic [2:0] age;
  logic       noresp;
  logic [4:0] oldest;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      age    <= 3'h0;
      noresp <= 1'b0;
      oldest <= 5'h00;
    end
    else
    begin
      age <= {age[1:0], i_ctrl.link_req};
      if (i_ctrl.link_req)
        noresp <= NORESP[i_ctrl.link_req_cmd];
      // Discard or reload leaves nothing older than the next tag
      if (i_ctrl.discard_tags || i_ctrl.tx_tag_load)
        oldest <= i_ctrl.tx_next_tag;
    end
  end

  // Status fields show inverted junk outside the response cycle
  always_comb
  begin
    o_stat                       = i_knob;
    o_stat.req_sent              = age[0];
    o_stat.resp_rx               = age[2] && !noresp;
    o_stat.resp_tag_state        = age[2] ? RESP_TAG : ~RESP_TAG;
    o_stat.resp_link_state       = age[2] ? RESP_LINK : ~RESP_LINK;
    o_stat.tx_oldest_unacked_tag = oldest;
  end
endmodule

//--- verif/spr_csr_bench.sv
// Self-checking bench for the recovery register block
`timescale 1ns/1ps
module spr_csr_bench;
  localparam logic [4:0] TAG = 5'h15;
  localparam logic [4:0] LNK = 5'h0A;
  logic                    i_sys_clk   = 1'b0;
  logic                    i_rst_b     = 1'b0;
  logic                    i_ce        = 1'b1;
  logic [11:0]             i_addr      = 12'h000;
  logic [31:0]             i_wdata     = 32'h0000_0000;
  logic                    i_wr        = 1'b0;
  logic                    i_rd        = 1'b0;
  logic [31:0]             o_rdata;
  spr_pkg::spr_port_stat_t knob        = '0;
  spr_pkg::spr_port_stat_t stat;
  spr_pkg::spr_port_ctrl_t o_ctrl;
  int                      errors      = 0;
  int                      comparisons = 0;

  always #2 i_sys_clk = ~i_sys_clk;

  spr_csr #(.NEXT_PTR(16'h0100)) DUT (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_stat(stat), .o_ctrl(o_ctrl));
  spr_port_model #(.RESP_TAG(TAG), .RESP_LINK(LNK)) PEER (.i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b), .i_ctrl(o_ctrl), .i_knob(knob), .o_stat(stat));

  // ----
  // Bus and compare tasks
  // ----
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string name);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    chk(name, o_rdata, exp);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    rdc(spr_pkg::OFS_BLOCK_HEADER, 32'h0002_0100, "header");
    rdc(spr_pkg::OFS_LINK_TIMEOUT, 32'h00FF_FFFF, "link_to");
    rdc(spr_pkg::OFS_RESP_TIMEOUT, 32'h00FF_FFFF, "resp_to");
    rdc(spr_pkg::OFS_GENERAL_CTRL, 32'h0000_0000, "gen");
    rdc(spr_pkg::OFS_LINK_REQUEST, 32'h0000_0000, "req");
    rdc(spr_pkg::OFS_LINK_RESPONSE, 32'h0000_0000, "rsp");
    rdc(spr_pkg::OFS_LOCAL_TAG, 32'h0000_0000, "tags");
    rdc(spr_pkg::OFS_ERROR_STATUS, 32'h8000_0000, "status");
    chk("ctl_link_to", 32'(o_ctrl.link_timeout), 32'h00FF_FFFF);
  endtask

  task automatic t_ctrl();
    wr(spr_pkg::OFS_LINK_TIMEOUT, 32'hAB12_3456);
    chk("ctl_link_to", 32'(o_ctrl.link_timeout), 32'h0012_3456);
    rdc(spr_pkg::OFS_LINK_TIMEOUT, 32'h0012_3456, "link_to");
    wr(spr_pkg::OFS_RESP_TIMEOUT, 32'hCD65_4321);
    chk("ctl_resp_to", 32'(o_ctrl.resp_timeout), 32'h0065_4321);
    rdc(spr_pkg::OFS_RESP_TIMEOUT, 32'h0065_4321, "resp_to");
    wr(spr_pkg::OFS_GENERAL_CTRL, 32'hFFFF_FFFD);
    chk("host", 32'(o_ctrl.host), 32'h1);
    chk("permit", 32'(o_ctrl.req_permit), 32'h0);
    chk("disc", 32'(o_ctrl.discovered), 32'h1);
    rdc(spr_pkg::OFS_GENERAL_CTRL, 32'h0000_0005, "gen");
    wr(spr_pkg::OFS_GENERAL_CTRL, 32'h0000_0002);
    chk("permit", 32'(o_ctrl.req_permit), 32'h1);
    rdc(spr_pkg::OFS_GENERAL_CTRL, 32'h0000_0002, "gen");
    wr(12'h004, 32'hFFFF_FFFF);
    rdc(12'h004, 32'h0000_0000, "unmapped");
    wr(spr_pkg::OFS_BLOCK_HEADER, 32'h0000_0000);
    rdc(spr_pkg::OFS_BLOCK_HEADER, 32'h0002_0100, "header");
  endtask

  // Strobes are lost while the enable is low
  task automatic t_freeze();
    @(posedge i_sys_clk);
    i_ce <= 1'b0;
    wr(spr_pkg::OFS_LINK_TIMEOUT, 32'h0000_0001);
    chk("frozen", 32'(o_ctrl.link_timeout), 32'h0012_3456);
    @(posedge i_sys_clk);
    i_ce <= 1'b1;
    rdc(spr_pkg::OFS_LINK_TIMEOUT, 32'h0012_3456, "frozen_rb");
  endtask

  // Command 3 expects no response, so valid rides on the send
  task automatic t_req();
    for (int c = 0; c < 8; c++)
    begin
      wr(spr_pkg::OFS_LINK_REQUEST, {c[2:0], 29'h1FFF_FFFF});
      chk("link_req", 32'(o_ctrl.link_req), 32'h1);
      chk("req_cmd", 32'(o_ctrl.link_req_cmd), 32'(c[2:0]));
      tick(1);
      #1;
      chk("link_req_end", 32'(o_ctrl.link_req), 32'h0);
      rdc(spr_pkg::OFS_LINK_REQUEST, {c[2:0], 29'h0}, "req_rb");
      tick(6);
      rdc(spr_pkg::OFS_LINK_RESPONSE, {LNK, TAG, 21'h0, 1'b1}, "rsp_set");
      rdc(spr_pkg::OFS_LINK_RESPONSE, {LNK, TAG, 22'h0}, "rsp_clr");
    end
  endtask

  task automatic t_tags();
    @(posedge i_sys_clk);
    knob.rx_expected_tag <= 5'h0C;
    wr(spr_pkg::OFS_LOCAL_TAG, 32'hFFFF_FFFF);
    chk("discard", 32'(o_ctrl.discard_tags), 32'h1);
    chk("load", 32'(o_ctrl.tx_tag_load), 32'h1);
    chk("tx_tag", 32'(o_ctrl.tx_next_tag), 32'h1F);
    tick(2);
    rdc(spr_pkg::OFS_LOCAL_TAG, 32'hF8F8_0060, "tags");
    wr(spr_pkg::OFS_LOCAL_TAG, 32'h0000_0001);
    chk("discard", 32'(o_ctrl.discard_tags), 32'h1);
    @(posedge i_sys_clk);
    knob.tx_tag_adv <= 1'b1;
    @(posedge i_sys_clk);
    knob.tx_tag_adv <= 1'b0;
    #1;
    chk("tx_tag_adv", 32'(o_ctrl.tx_next_tag), 32'h01);
    rdc(spr_pkg::OFS_LOCAL_TAG, 32'h0800_0060, "tags");
  endtask

  task automatic t_status();
    @(posedge i_sys_clk);
    knob.out_retry_stop <= 1'b1;
    tick(2);
    rdc(spr_pkg::OFS_ERROR_STATUS, 32'h8000_3800, "retry_on");
    @(posedge i_sys_clk);
    knob.out_retry_stop <= 1'b0;
    knob.ack_rx         <= 1'b1;
    @(posedge i_sys_clk);
    knob.ack_rx <= 1'b0;
    tick(1);
    rdc(spr_pkg::OFS_ERROR_STATUS, 32'h8000_0800, "retry_off");
    wr(spr_pkg::OFS_ERROR_STATUS, 32'h0000_0800);
    rdc(spr_pkg::OFS_ERROR_STATUS, 32'h8000_0000, "w1c");
    @(posedge i_sys_clk);
    knob.out_err_stop  <= 1'b1;
    knob.in_retry_stop <= 1'b1;
    knob.in_err_stop   <= 1'b1;
    knob.pw_event      <= 1'b1;
    knob.fatal_event   <= 1'b1;
    knob.port_ok       <= 1'b1;
    tick(2);
    rdc(spr_pkg::OFS_ERROR_STATUS, 32'h68E0_C000, "all_on");
    @(posedge i_sys_clk);
    knob <= '0;
    tick(2);
    rdc(spr_pkg::OFS_ERROR_STATUS, 32'hA840_4000, "sticky");
    wr(spr_pkg::OFS_ERROR_STATUS, 32'hFFFF_FFFF);
    rdc(spr_pkg::OFS_ERROR_STATUS, 32'h8000_0000, "cleared");
  endtask

  // ----
  // Run control
  // ----
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    t_reset();
    t_ctrl();
    t_freeze();
    t_req();
    t_tags();
    t_status();
    summarize();
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge i_sys_clk);
    errors++;
    summarize();
  end
endmodule
